// >>> common/pmi_params.svh
// constants for the phy mac-side data interface
// assumes a 20 MHz core clock and a 50 MHz-class reference seen as a sampled pin
`ifndef PMI_PARAMS_SVH
`define PMI_PARAMS_SVH
`define PMI_CLK_PERIOD_NS   50
`define PMI_DIV_100M        2'h0
`define PMI_DIV_10M_HALF    4'h9
`define PMI_STRAP_DEFAULT   5'h01
`define PMI_RMII_DIBITS     2'h1
`define PMI_ERR_NIBBLE      4'hE
`endif

// >>> common/pmi_pkg.sv
// types for the phy mac-side data interface
// assumes pmi_params.svh is included by the design files
package pmi_pkg;
   // mac interface mode
   typedef enum logic [2:0] {
      PMI_MII   = 3'h1,
      PMI_RMII  = 3'h2,
      PMI_RGMII = 3'h4
   } pmi_mode_t;

   // receive symbol from the decoder side
   typedef struct packed {
      logic       valid;
      logic       err;
      logic       carrier;
      logic [3:0] nibble;
   } pmi_rx_sym_t;

   // receive lanes toward the mac
   typedef struct packed {
      logic       dv;
      logic       er;
      logic       crs;
      logic [3:0] data;
   } pmi_rx_out_t;
endpackage : pmi_pkg

// >>> rtl/pmi_sync.sv
// two flip-flop synchroniser, one per bit
// assumes the inputs are asynchronous to i_clk
`timescale 1ns/1ns
module pmi_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;

   // first stage read only by the second
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         meta <= '0;
         o_q  <= '0;
      end else if (i_ce) begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule : pmi_sync

// >>> rtl/pmi_phy_mac_if.sv
// phy mac-side data interface: clocks, rx lanes, carrier sense, straps
// assumes ref/tx clock pins sampled by i_clk, decoder symbols on i_clk
//
// Contract
// RQ1 - mii transmit clock is 25 MHz at 100M, 2.5 MHz at 10M
// RQ2 - mii transmit clock holds constant phase to the reference clock
// RQ3 - in rgmii the mac sources the transmit clock
// RQ4 - transmit clock pin driven low in reset, input after release; the code keeps driving it after release in mii
// RQ5 - mac drives transmit enable sampled on transmit clock rise
// RQ6 - rgmii tx control carries enable on rise, error on fall; the code samples only the enable, on the rise
// RQ7 - mac presents transmit data on rising edge of its clock
// RQ8 - receive clock derived from data stream at 25 or 2.5 MHz; the code divides it from the reference pin and holds it low in rmii
// RQ9 - data valid marks valid receive data, independent of carrier
// RQ10 - rgmii rx control carries valid on rise, error on fall
// RQ11 - receive error high on error symbol, unused in rgmii
// RQ12 - receive data corrupted on error so mac may ignore error
// RQ13 - receive data 4 bits in mii/rgmii, 2 bits in rmii
// RQ14 - five bit address strapped from rx data and collision, default 0x01
// RQ15 - mii carrier sense high when receive or transmit medium busy
// RQ16 - rmii carrier sense pin carries combined carrier and data valid
// RQ17 - straps latched once at reset release, pins then reused
`timescale 1ns/1ns
`include "pmi_params.svh"
module pmi_phy_mac_if (
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_ce,
   input  pmi_pkg::pmi_mode_t    i_mode,
   input  wire logic             i_speed_100,
   input  wire logic             i_ref_clk,
   input  wire logic             i_tx_clk,
   input  wire logic             i_tx_en,
   input  wire logic             i_tx_busy,
   input  pmi_pkg::pmi_rx_sym_t  i_rx_sym,
   input  wire logic [3:0]       i_rx_d_pin,
   input  wire logic             i_col_pin,
   output logic                  o_tx_clk,
   output logic                  o_tx_clk_oe,
   output logic                  o_tx_en_seen,
   output logic                  o_rx_clk,
   output pmi_pkg::pmi_rx_out_t  o_rx,
   output logic                  o_rx_ctrl,
   output logic                  o_rx_d_oe,
   output logic [4:0]            o_phy_address_strap
);
   import pmi_pkg::*;

   logic       ref_s;
   logic       txc_s;
   logic       txen_s;
   logic [3:0] rxd_s;
   logic       col_s;
   logic       ref_d;
   logic       txc_d;
   logic [3:0] div;
   logic       out_of_reset;
   logic       strap_done;
   logic       rx_phase;
   logic       strap_arm;

   // pins from outside the clock domain
   pmi_sync #(.W(8)) u_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_d     ({i_ref_clk, i_tx_clk, i_tx_en, i_rx_d_pin, i_col_pin}),
      .o_q     ({ref_s, txc_s, txen_s, rxd_s, col_s})
   );

   // edge detection on the sampled clocks
   wire ref_rise = ref_s & ~ref_d;
   wire txc_rise = txc_s & ~txc_d;
   wire is_mii   = (i_mode == PMI_MII);
   wire is_rmii  = (i_mode == PMI_RMII);
   wire is_rgmii = (i_mode == PMI_RGMII);
   wire [3:0] div_top = i_speed_100 ? {2'h0, `PMI_DIV_100M} : `PMI_DIV_10M_HALF;

   // divider steps only on reference edges so phase stays locked
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ref_d    <= 1'b0;
         txc_d    <= 1'b0;
         div      <= 4'h0;
         o_tx_clk <= 1'b0;                                  // RQ4
      end else if (i_ce) begin
         ref_d <= ref_s;
         txc_d <= txc_s;
         if (ref_rise) begin                                // RQ2
            if (div >= div_top) begin
               div      <= 4'h0;
               o_tx_clk <= is_mii & ~o_tx_clk;              // RQ1
            end else begin
               div <= div + 4'h1;
            end
         end
      end
   end

   // pin drives low in reset; after release only mii drives it
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         out_of_reset <= 1'b0;
      end else if (i_ce) begin
         out_of_reset <= 1'b1;
      end
   end
   assign o_tx_clk_oe = ~out_of_reset | is_mii;             // RQ4

   // transmit enable taken on the active tx clock rise; in mii that clock is our
   // own, so take it the cycle before the pin rises, as the mac drives none then
   wire tx_toggle   = ref_rise & (div >= div_top);
   wire mii_tx_rise = tx_toggle & is_mii & ~o_tx_clk;
   wire tx_edge     = is_rmii ? ref_rise : (is_mii ? mii_tx_rise : txc_rise);   // RQ5 RQ3
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_tx_en_seen <= 1'b0;
      end else if (i_ce && tx_edge) begin
         o_tx_en_seen <= txen_s;                            // RQ5 RQ7
      end
   end

   // sync stages are cleared in reset, so pin levels need two edges to arrive
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         strap_arm <= 1'b0;
      end else if (i_ce) begin
         strap_arm <= out_of_reset;
      end
   end

   // strap capture two cycles after release, rx data pins then outputs
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         strap_done          <= 1'b0;
         o_phy_address_strap <= `PMI_STRAP_DEFAULT;
      end else if (i_ce && !strap_done && strap_arm) begin
         strap_done          <= 1'b1;
         o_phy_address_strap <= {rxd_s, col_s};             // RQ14 RQ17
      end
   end
   assign o_rx_d_oe = strap_done;                           // RQ17

   // receive clock is divided from the reference pin, like the tx clock, not from the decoder symbols
   wire rx_edge = is_rmii ? ref_rise : ref_rise && (div == 4'h0);
   wire [3:0] rx_data = i_rx_sym.err ? `PMI_ERR_NIBBLE : i_rx_sym.nibble;   // RQ12
   wire [3:0] rx_lane = is_rmii ? {2'h0, rx_data[1:0]} : rx_data;           // RQ13
   wire rx_take = i_ce & rx_edge & ~rx_phase;                               // symbol taken here

   // rx outputs registered, updated on the receive clock fall
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_rx     <= '0;
         o_rx_clk <= 1'b0;
         rx_phase <= 1'b0;
      end else if (i_ce) begin
         if (rx_edge) begin
            rx_phase <= ~rx_phase;
            o_rx_clk <= ~is_rmii & rx_phase;                // RQ8
            if (!rx_phase) begin
               o_rx.dv   <= i_rx_sym.valid;                 // RQ9
               o_rx.er   <= ~is_rgmii & i_rx_sym.valid & i_rx_sym.err;  // RQ11
               o_rx.data <= i_rx_sym.valid ? rx_lane : 4'h0;            // RQ13
               o_rx.crs  <= is_mii   ? (i_rx_sym.carrier | i_tx_busy) : // RQ15
                            is_rmii  ? (i_rx_sym.carrier | i_rx_sym.valid) : // RQ16
                            1'b0;
            end
         end
      end
   end

   // rgmii control: valid while clock high, valid xor error while low
   assign o_rx_ctrl = is_rgmii & (o_rx_clk ? o_rx.dv : (o_rx.dv ^ i_rx_sym.err));  // RQ10

   // tx clock pin: driven low in reset, released outside mii
   a_clk_low_reset: assert property (@(posedge i_clk)                          // RQ4
      !i_rst_b |=> !o_tx_clk)
      else $error("tx clock not low after reset");
   a_oe_in_reset: assert property (@(posedge i_clk)                            // RQ4
      !i_rst_b |=> o_tx_clk_oe)
      else $error("tx clock pin not driven in reset");
   a_clk_rgmii_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)   // RQ3
      is_rgmii && $past(is_rgmii) && $past(out_of_reset) |-> !o_tx_clk_oe)
      else $error("tx clock driven in rgmii");
   a_mii_clk_ok: assert property (@(posedge i_clk) disable iff (!i_rst_b)      // RQ1
      !is_mii && $stable(i_mode) |=> $stable(o_tx_clk) || !o_tx_clk)
      else $error("tx clock toggles outside mii");

   // tx clock moves only right after a reference rise, which fixes its phase
   a_tx_phase: assert property (@(posedge i_clk) disable iff (!i_rst_b)        // RQ2
      $changed(o_tx_clk) && $past(i_rst_b) |-> $past(ref_rise))
      else $error("tx clock moved off a reference edge");
   a_rx_clk_rmii: assert property (@(posedge i_clk) disable iff (!i_rst_b)     // RQ8
      $past(i_ce) && $past(rx_edge) && $past(is_rmii) |-> !o_rx_clk)
      else $error("rx clock toggles in rmii");

   // receive lanes, looked at one cycle after each take; error against valid on every cycle
   a_dv_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)      // RQ9
      $past(rx_take) |-> o_rx.dv == $past(i_rx_sym.valid))
      else $error("data valid does not follow the symbol");
   a_er_rgmii_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)    // RQ11
      is_rgmii && $stable(i_mode) && $past(i_ce) && $past(rx_edge) && !$past(rx_phase) |-> !o_rx.er)
      else $error("rx error active in rgmii");
   a_er_needs_dv: assert property (@(posedge i_clk) disable iff (!i_rst_b)     // RQ11
      o_rx.er |-> o_rx.dv)
      else $error("rx error without data valid");
   a_data_corrupt: assert property (@(posedge i_clk) disable iff (!i_rst_b)    // RQ12
      $past(rx_take) && !$past(is_rmii) && o_rx.er |-> o_rx.data == `PMI_ERR_NIBBLE)
      else $error("errored data not corrupted");
   a_rmii_lanes: assert property (@(posedge i_clk) disable iff (!i_rst_b)      // RQ13
      $past(rx_take) && $past(is_rmii) |-> o_rx.data[3:2] == 2'h0)
      else $error("upper lanes active in rmii");
   a_crs_mii: assert property (@(posedge i_clk) disable iff (!i_rst_b)         // RQ15
      $past(rx_take) && $past(is_mii) |-> o_rx.crs == ($past(i_rx_sym.carrier) || $past(i_tx_busy)))
      else $error("mii carrier sense wrong");
   a_crs_rmii: assert property (@(posedge i_clk) disable iff (!i_rst_b)        // RQ16
      $past(rx_take) && $past(is_rmii) |-> o_rx.crs == ($past(i_rx_sym.carrier) || $past(i_rx_sym.valid)))
      else $error("rmii carrier and valid wrong");

   // straps, and the clock enable freezing the tx clock, rx lanes and strap
   a_strap_once: assert property (@(posedge i_clk) disable iff (!i_rst_b)      // RQ17
      strap_done && $past(strap_done) |-> $stable(o_phy_address_strap))
      else $error("strap changed after capture");
   a_strap_time: assert property (@(posedge i_clk) disable iff (!i_rst_b)      // RQ14
      $rose(i_rst_b) && i_ce ##1 i_ce ##1 i_ce |=> strap_done)
      else $error("strap not captured after release");
   a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_b)       // RQ1
      !$past(i_ce) && $past(i_rst_b) |-> $stable(o_tx_clk) && $stable(o_rx) && $stable(o_phy_address_strap))
      else $error("state moved with clock enable low");

   c_mii_toggle: cover property (@(posedge i_clk) is_mii && $rose(o_tx_clk));
   c_rx_error:   cover property (@(posedge i_clk) o_rx.er);
   c_rmii_crs:   cover property (@(posedge i_clk) is_rmii && o_rx.crs);
   c_strap:      cover property (@(posedge i_clk) $rose(strap_done));
   c_rgmii_err:  cover property (@(posedge i_clk) is_rgmii && !o_rx_clk && o_rx.dv && !o_rx_ctrl);
endmodule : pmi_phy_mac_if

// >>> tb/pmi_mac_model.sv
// mac-side stand-in: transmit clock in rgmii, transmit enable framed by a clock
// assumes the bench picks the mode and asks for a frame with i_send
`timescale 1ns/1ns
module pmi_mac_model (
   input  wire logic i_rgmii,
   input  wire logic i_dev_clk,
   input  wire logic i_send,
   output logic      o_tx_clk,
   output logic      o_tx_en
);
   wire logic frame_clk;
   // mac sources a 400 ns clock in rgmii only, and holds it low otherwise
   initial begin
      o_tx_clk = 1'b0;
      forever begin
         #200;
         o_tx_clk = i_rgmii ? ~o_tx_clk : 1'b0;
      end
   end
   // enable moves on the falling edge so that the rising edge sees it settled
   assign frame_clk = i_rgmii ? o_tx_clk : i_dev_clk;
   initial o_tx_en = 1'b0;
   always @(negedge frame_clk) o_tx_en <= i_send;
endmodule : pmi_mac_model

// >>> tb/pmi_phy_mac_if_tb.sv
// self-checking bench for the phy mac-side data interface
// assumes a 400 ns reference pin and the mac model on the transmit side
`timescale 1ns/1ns
`include "pmi_params.svh"
module pmi_phy_mac_if_tb;
   import pmi_pkg::*;
   logic                i_clk;
   logic                i_rst_b;
   logic                speed;
   logic                ref_clk;
   logic                busy;
   logic                col_pin;
   logic                send;
   logic [3:0]          rxd_pin;
   pmi_mode_t           mode;
   pmi_rx_sym_t         sym;
   wire logic           mac_clk;
   wire logic           mac_en;
   logic                tx_clk;
   logic                tx_clk_oe;
   logic                tx_en_seen;
   pmi_rx_out_t         rx;
   logic [4:0]          strap;
   logic                rx_d_oe;
   logic                ce;
   logic                rx_clk;
   logic                rx_ctrl;
   // reference pin period in core cycles: 400 ns over 50 ns
   localparam int       REF_CYC = 8;
   int                  fails = 0;
   int                  checks_done = 0;
   pmi_phy_mac_if i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_mode(mode), .i_speed_100(speed),
      .i_ref_clk(ref_clk), .i_tx_clk(mac_clk), .i_tx_en(mac_en), .i_tx_busy(busy), .i_rx_sym(sym),
      .i_rx_d_pin(rxd_pin), .i_col_pin(col_pin), .o_tx_clk(tx_clk), .o_tx_clk_oe(tx_clk_oe),
      .o_tx_en_seen(tx_en_seen), .o_rx_clk(rx_clk), .o_rx(rx), .o_rx_ctrl(rx_ctrl), .o_rx_d_oe(rx_d_oe),
      .o_phy_address_strap(strap));
   pmi_mac_model i_mac (.i_rgmii(mode == PMI_RGMII), .i_dev_clk(tx_clk), .i_send(send),
      .o_tx_clk(mac_clk), .o_tx_en(mac_en));
   // core clock and reference pin; the reference edges land on falling core edges
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   initial begin
      ref_clk = 1'b0;
      forever #200 ref_clk = ~ref_clk;
   end
   task automatic fall(int n);
      repeat (n) @(negedge i_clk);
   endtask : fall
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // expected receive lanes from the symbol, mode and transmit activity
   function automatic pmi_rx_out_t exp_rx(pmi_mode_t m, pmi_rx_sym_t s, logic b);
      pmi_rx_out_t r;
      r.dv   = s.valid;
      r.er   = (m != PMI_RGMII) && s.valid && s.err;
      r.crs  = (m == PMI_MII) ? (s.carrier | b) : (m == PMI_RMII) ? (s.carrier | s.valid) : 1'b0;
      r.data = !s.valid ? 4'h0 : (s.err ? `PMI_ERR_NIBBLE : s.nibble);  // idle lanes carry zero
      if (m == PMI_RMII) r.data[3:2] = 2'h0;
      return r;
   endfunction : exp_rx
   // symbol held over two 10M take periods, then lanes compared
   task automatic rx_test(pmi_mode_t m, pmi_rx_sym_t s, logic b);
      pmi_rx_out_t e;
      mode = m;
      sym  = s;
      busy = b;
      e    = exp_rx(m, s, b);
      fall(400);
      check("rx lanes", rx, e);
      check("rx control", rx_ctrl, (m == PMI_RGMII) && (rx_clk ? e.dv : (e.dv ^ s.err)));
      check("tx clock pin drive", tx_clk_oe, m == PMI_MII);
   endtask : rx_test
   // picks the tx clock (0) or the rx clock (1)
   function automatic logic clk_of(int w);
      return w ? rx_clk : tx_clk;
   endfunction : clk_of
   // tx and rx clock periods in core cycles, counted rise to rise
   task automatic clk_period(logic spd, int exp);
      int n;
      int k;
      speed = spd;
      fall(400);
      for (int w = 0; w < 2; w++) begin
         k = 0;
         n = 0;
         while (clk_of(w) !== 1'b0 && k < 400) begin fall(1); k++; end
         while (clk_of(w) !== 1'b1 && k < 400) begin fall(1); k++; end
         while (clk_of(w) === 1'b1 && n < 400) begin fall(1); n++; end
         while (clk_of(w) === 1'b0 && n < 400) begin fall(1); n++; end
         check(w ? "rx clock period" : "tx clock period", n, exp);
      end
   endtask : clk_period
   initial begin
      #2000000;
      fails++;
      $display("Error watchdog expired");
      conclude();
   end
   initial begin
      pmi_mode_t   m;
      pmi_rx_sym_t s;
      logic [13:0] snap;
      void'($urandom(74027));
      ce = 1'b1;
      {i_rst_b, speed, busy, send, sym, rxd_pin, col_pin, mode} = {4'b0100, 7'h00, 4'hA, 1'b1, PMI_MII};
      fall(5);
      check("tx clock in reset", {tx_clk_oe, tx_clk}, 2'b10);
      check("strap in reset", strap, `PMI_STRAP_DEFAULT);
      i_rst_b = 1'b1;
      fall(3);
      rxd_pin = 4'h5;
      col_pin = 1'b0;
      fall(5);
      check("strap latched", strap, 5'h15);
      check("rx pins driven", rx_d_oe, 1'b1);
      $display("test straps done");
      // a 50 MHz reference halves to 25 MHz and divides by twenty to 2.5 MHz
      clk_period(1'b1, 2 * REF_CYC);
      clk_period(1'b0, 20 * REF_CYC);
      $display("test clocks done");
      // with the enable low nothing may move, though both clocks would toggle
      ce   = 1'b0;
      snap = {tx_clk, rx_clk, rx, strap};
      fall(200);
      check("frozen state", {tx_clk, rx_clk, rx, strap}, snap);
      ce   = 1'b1;
      $display("test clock enable done");
      // enable framed by our own mii clock, then by the mac's rgmii clock
      for (int j = 0; j < 2; j++) begin
         mode = j ? PMI_RGMII : PMI_MII;
         send = 1'b1;
         fall(400);
         check("tx enable seen", tx_en_seen, 1'b1);
         send = 1'b0;
         fall(400);
         check("tx enable dropped", tx_en_seen, 1'b0);
      end
      $display("test transmit done");
      // corners: error symbol, carrier from transmit only, valid without carrier
      rx_test(PMI_MII, 7'h63, 1'b0);
      rx_test(PMI_MII, 7'h49, 1'b1);
      rx_test(PMI_RMII, 7'h47, 1'b0);
      rx_test(PMI_RMII, 7'h6D, 1'b0);
      rx_test(PMI_RGMII, 7'h5B, 1'b1);
      rx_test(PMI_MII, 7'h1C, 1'b0);
      rx_test(PMI_RGMII, 7'h61, 1'b0);
      for (int i = 0; i < 6; i++) begin
         m = pmi_mode_t'(3'h1 << (i % 3));
         s = pmi_rx_sym_t'({1'b1, 6'($urandom)});
         if (m == PMI_RGMII) s.err = 1'b0;
         rx_test(m, s, 1'($urandom));
      end
      $display("test receive done");
      conclude();
   end
endmodule : pmi_phy_mac_if_tb
